// ---- design/lpsl_pkg.sv ----
// Purpose: shared constants for the port line status latch and interrupt block
// Assumes: one port copy per instance, AXI4-Lite register access
// Notes: register offsets are word indices; byte address is four times index
package lpsl_pkg;
	localparam int unsigned STAT_W      = 16;
	localparam int unsigned GAIN_W      = 8;
	localparam int unsigned AXI_DW      = 32;
	localparam int unsigned PORT_STRIDE = 32'h0000_0080;
	localparam int unsigned PORT_MAX    = 3;
	localparam int unsigned IDX_LIVE    = 32'h0000_0028;
	localparam int unsigned IDX_LAT     = 32'h0000_002a;
	localparam int unsigned IDX_EN      = 32'h0000_002c;
	localparam int unsigned IDX_GAIN    = 32'h0000_002e;
	localparam int unsigned IDX_CLR     = 32'h0000_0030;
	localparam int unsigned IDX_CTL     = 32'h0000_0032;
	localparam int unsigned B_ANALOG_SIGLOSS_LIVE      = 0;
	localparam int unsigned B_LOCK      = 1;
	localparam int unsigned B_RX_TWO    = 2;
	localparam int unsigned B_RX_ONE    = 3;
	localparam int unsigned B_PREAMP    = 4;
	localparam int unsigned B_GAIN_CHG  = 5;
	localparam int unsigned B_REF_CLK   = 8;
	localparam int unsigned B_TX_OUT    = 9;
	localparam int unsigned B_DRV       = 10;
	localparam int unsigned B_JB_EMPTY  = 11;
	localparam int unsigned B_JB_FULL   = 12;
	localparam int unsigned B_JB_LOST   = 13;
	localparam int unsigned C_GRP       = 0;
	localparam int unsigned C_GLOB      = 1;
	localparam logic [15:0] VALID_MASK  = 16'h1f3f;
	localparam logic [15:0] LIVE_MASK   = 16'h071f;
	localparam logic [15:0] CHG_MASK    = 16'h061f;
	localparam logic [15:0] RST_LAT     = 16'h0000;
	localparam logic [15:0] RST_EN      = 16'h0000;
	localparam logic [1:0]  RST_CTL     = 2'h0;
	localparam logic [2:0]  PRIME_CYC   = 3'h5;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : lpsl_pkg

// ---- design/lpsl_evt_if.sv ----
// Purpose: carries synchronised live status, gain and event pulses
// Assumes: single clock domain
// Notes: src drives, dst reads
`timescale 1ns/1ps
`default_nettype none
interface lpsl_evt_if;
	logic [15:0] live;
	logic [15:0] evt;
	logic [7:0]  gain;
	modport src (output live, output evt, output gain);
	modport dst (input live, input evt, input gain);
endinterface : lpsl_evt_if
`default_nettype wire

// ---- design/lpsl_evt_detect.sv ----
// Purpose: synchronises front end status and turns it into event pulses
// Assumes: raw inputs are asynchronous to core_clk_i
// Notes: events held off until the pipeline holds real samples
`timescale 1ns/1ps
`default_nettype none
module lpsl_evt_detect (
	input  wire logic [lpsl_pkg::STAT_W-1:0] raw_i,
	input  wire logic [lpsl_pkg::GAIN_W-1:0] gain_raw_i,
	input  wire logic                        core_clk_i,
	input  wire logic                        arst_n_i,
	lpsl_evt_if.src                          evt_if
);
	import lpsl_pkg::*;
	logic [STAT_W-1:0] s1_ff, s2_ff, live_ff, evt_ff, nxt_evt, rise, chg;
	logic [GAIN_W-1:0] g1_ff, g2_ff, g3_ff, gain_ff;
	logic [2:0]        prime_ff;
	logic              primed;
	logic              gain_upd;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_ff   <= '0;
			s2_ff   <= '0;
			live_ff <= '0;
			g1_ff   <= '0;
			g2_ff   <= '0;
			g3_ff   <= '0;
		end else begin
			s1_ff   <= raw_i;
			s2_ff   <= s1_ff;
			live_ff <= s2_ff;
			g1_ff   <= gain_raw_i;
			g2_ff   <= g1_ff;
			g3_ff   <= g2_ff;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			prime_ff <= '0;
		else if (!primed)
			prime_ff <= prime_ff + 3'h1;
	end

	// gain taken only once two samples agree, so a skewed bus update is not seen
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			gain_ff <= '0;
		else if (gain_upd)
			gain_ff <= g2_ff;
	end

	always_comb begin
		primed   = (prime_ff == PRIME_CYC);
		rise     = s2_ff & ~live_ff;
		chg      = s2_ff ^ live_ff;
		gain_upd = (g2_ff == g3_ff) && (g2_ff != gain_ff);
		nxt_evt  = '0;
		if (primed) begin
			nxt_evt             = chg & CHG_MASK;
			nxt_evt[B_REF_CLK]  = rise[B_REF_CLK];
			nxt_evt[B_JB_FULL]  = rise[B_JB_FULL] | rise[B_JB_LOST];
			nxt_evt[B_JB_EMPTY] = rise[B_JB_EMPTY] | rise[B_JB_LOST];
			nxt_evt[B_GAIN_CHG] = gain_upd;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			evt_ff <= '0;
		else
			evt_ff <= nxt_evt;
	end

	assign evt_if.live = live_ff & LIVE_MASK;
	assign evt_if.evt  = evt_ff;
	assign evt_if.gain = gain_ff;

	property p_drv_chg;
		primed && chg[B_DRV] |=> evt_ff[B_DRV] && (live_ff[B_DRV] != $past(live_ff[B_DRV]));
	endproperty
	a_drv_chg: assert property (p_drv_chg) else $error("driver fault change missed");
	property p_ref_rise;
		primed && rise[B_REF_CLK] |=> evt_ff[B_REF_CLK];
	endproperty
	a_ref_rise: assert property (p_ref_rise) else $error("clock loss set missed");
	property p_ref_fall;
		live_ff[B_REF_CLK] && !s2_ff[B_REF_CLK] |=> !evt_ff[B_REF_CLK];
	endproperty
	a_ref_fall: assert property (p_ref_fall) else $error("clock loss clear raised event");
	property p_gain_chg;
		primed && gain_upd |=> evt_ff[B_GAIN_CHG] && (gain_ff != $past(gain_ff));
	endproperty
	a_gain_chg: assert property (p_gain_chg) else $error("gain change missed");
endmodule : lpsl_evt_detect
`default_nettype wire

// ---- design/lpsl_status_irq.sv ----
// Purpose: per port line status latch, interrupt enables and AXI4-Lite registers
// Assumes: front end status pins asynchronous; AXI4-Lite on core_clk_i
// Notes: one write and one read in flight; irq_o is registered
// Operation
// - set full flag on full or data loss
// - set empty flag on empty or data loss
// - set driver flag on any driver change
// - set output flag on any output change
// - set clock loss flag only on set
// - set gain flag when gain value changes
// - set preamp flag on preamp change
// - set receive failure flags on their change
// - set lock flag on lock change
// - set signal loss flag on change
// - interrupt needs flag, group, global enables
// - enable bit beside flag, one allows
// - report live gain, quarter dB steps
// - high codes give negative gain
// - live signal loss bit reads condition
// - live driver bit reads driver fault
// - live output bit reads open or short
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lpsl_status_irq #(
	parameter int unsigned PORT_IDX = 0,
	parameter int unsigned ADDR_W   = 12
) (
	input  wire logic                        core_clk_i,
	input  wire logic                        arst_n_i,
	input  wire logic [ADDR_W-1:0]           axi_awaddr_i,
	input  wire logic                        axi_awvalid_i,
	output logic                             axi_awready_o,
	input  wire logic [lpsl_pkg::AXI_DW-1:0] axi_wdata_i,
	input  wire logic [3:0]                  axi_wstrb_i,
	input  wire logic                        axi_wvalid_i,
	output logic                             axi_wready_o,
	output logic [1:0]                       axi_bresp_o,
	output logic                             axi_bvalid_o,
	input  wire logic                        axi_bready_i,
	input  wire logic [ADDR_W-1:0]           axi_araddr_i,
	input  wire logic                        axi_arvalid_i,
	output logic                             axi_arready_o,
	output logic [lpsl_pkg::AXI_DW-1:0]      axi_rdata_o,
	output logic [1:0]                       axi_rresp_o,
	output logic                             axi_rvalid_o,
	input  wire logic                        axi_rready_i,
	input  wire logic                        jbuf_full_i,
	input  wire logic                        jbuf_empty_i,
	input  wire logic                        jbuf_lost_i,
	input  wire logic                        drv_fault_live_i,
	input  wire logic                        tx_out_fault_live_i,
	input  wire logic                        ref_clock_loss_live_i,
	input  wire logic                        preamp_on_live_i,
	input  wire logic                        rx_fault_one_live_i,
	input  wire logic                        rx_fault_two_live_i,
	input  wire logic                        lock_loss_live_i,
	input  wire logic                        analog_sigloss_live_i,
	input  wire logic [lpsl_pkg::GAIN_W-1:0] gain_level_value_i,
	output logic                             irq_o
);
	import lpsl_pkg::*;

	localparam int unsigned BASE_B = PORT_IDX * PORT_STRIDE * 4;
	localparam logic [ADDR_W-1:0] A_LIVE = ADDR_W'(BASE_B + 4 * IDX_LIVE);
	localparam logic [ADDR_W-1:0] A_LAT  = ADDR_W'(BASE_B + 4 * IDX_LAT);
	localparam logic [ADDR_W-1:0] A_EN   = ADDR_W'(BASE_B + 4 * IDX_EN);
	localparam logic [ADDR_W-1:0] A_GAIN = ADDR_W'(BASE_B + 4 * IDX_GAIN);
	localparam logic [ADDR_W-1:0] A_CLR  = ADDR_W'(BASE_B + 4 * IDX_CLR);
	localparam logic [ADDR_W-1:0] A_CTL  = ADDR_W'(BASE_B + 4 * IDX_CTL);

	generate
		if (PORT_IDX > PORT_MAX || (BASE_B + 4 * IDX_CTL) >= (1 << ADDR_W)) begin : g_chk
			$error("port index or address width out of range");
		end
	endgenerate

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	lpsl_evt_if ev ();

	logic [STAT_W-1:0] raw;

	always_comb begin
		raw             = '0;
		raw[B_ANALOG_SIGLOSS_LIVE]     = analog_sigloss_live_i;
		raw[B_LOCK]     = lock_loss_live_i;
		raw[B_RX_TWO]   = rx_fault_two_live_i;
		raw[B_RX_ONE]   = rx_fault_one_live_i;
		raw[B_PREAMP]   = preamp_on_live_i;
		raw[B_REF_CLK]  = ref_clock_loss_live_i;
		raw[B_TX_OUT]   = tx_out_fault_live_i;
		raw[B_DRV]      = drv_fault_live_i;
		raw[B_JB_EMPTY] = jbuf_empty_i;
		raw[B_JB_FULL]  = jbuf_full_i;
		raw[B_JB_LOST]  = jbuf_lost_i;
	end

	lpsl_evt_detect u_detect (
		.raw_i      (raw),
		.gain_raw_i (gain_level_value_i),
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.evt_if     (ev.src)
	);

	// write channel state
	logic                aw_hold_ff;
	logic                w_hold_ff;
	logic [ADDR_W-1:0]   awaddr_ff;
	logic [AXI_DW-1:0]   wdata_ff;
	logic [3:0]          wstrb_ff;
	logic                bvalid_ff;
	logic [1:0]          bresp_ff;
	logic                do_wr;
	logic                wr_hit;
	logic [STAT_W-1:0]   wmask;
	logic [STAT_W-1:0]   wval;

	// read channel state
	logic                rvalid_ff;
	logic [AXI_DW-1:0]   rdata_ff;
	logic [1:0]          rresp_ff;
	logic [AXI_DW-1:0]   rd_word;
	logic                rd_hit;

	// status and control registers
	logic [STAT_W-1:0]   lat_ff;
	logic [STAT_W-1:0]   nxt_lat;
	logic [STAT_W-1:0]   en_ff;
	logic [1:0]          ctl_ff;
	logic [STAT_W-1:0]   clr;
	logic [STAT_W-1:0]   win;
	logic                irq_ff;
	logic                nxt_irq;

	assign axi_awready_o = !aw_hold_ff && !bvalid_ff;
	assign axi_wready_o  = !w_hold_ff && !bvalid_ff;
	assign axi_bvalid_o  = bvalid_ff;
	assign axi_bresp_o   = bresp_ff;
	assign axi_arready_o = !rvalid_ff;
	assign axi_rvalid_o  = rvalid_ff;
	assign axi_rdata_o   = rdata_ff;
	assign axi_rresp_o   = rresp_ff;
	assign irq_o         = irq_ff;

	always_comb begin
		do_wr  = aw_hold_ff && w_hold_ff && !bvalid_ff;
		wr_hit = (awaddr_ff == A_LIVE) || (awaddr_ff == A_LAT) || (awaddr_ff == A_EN) ||
		         (awaddr_ff == A_GAIN) || (awaddr_ff == A_CLR) || (awaddr_ff == A_CTL);
		wmask  = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
		wval   = wdata_ff[STAT_W-1:0] & wmask & VALID_MASK;
	end

	// address and data are taken independently, in either order
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_hold_ff <= 1'b0;
			awaddr_ff  <= '0;
		end else if (axi_awvalid_i && axi_awready_o) begin
			aw_hold_ff <= 1'b1;
			awaddr_ff  <= axi_awaddr_i;
		end else if (do_wr) begin
			aw_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w_hold_ff <= 1'b0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else if (axi_wvalid_i && axi_wready_o) begin
			w_hold_ff <= 1'b1;
			wdata_ff  <= axi_wdata_i;
			wstrb_ff  <= axi_wstrb_i;
		end else if (do_wr) begin
			w_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (axi_bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end

	// reads have no side effects; the clear register reads as zero
	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		if (axi_araddr_i == A_LIVE)
			rd_word[STAT_W-1:0] = ev.live;
		else if (axi_araddr_i == A_LAT)
			rd_word[STAT_W-1:0] = lat_ff;
		else if (axi_araddr_i == A_EN)
			rd_word[STAT_W-1:0] = en_ff;
		else if (axi_araddr_i == A_GAIN)
			rd_word[GAIN_W-1:0] = ev.gain;
		else if (axi_araddr_i == A_CLR)
			rd_word = '0;
		else if (axi_araddr_i == A_CTL)
			rd_word[1:0] = ctl_ff;
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (axi_arvalid_i && axi_arready_o) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (axi_rready_i) begin
			rvalid_ff <= 1'b0;
		end
	end

	// a one written to the latched register or its clear alias drops the flag
	always_comb begin
		clr = '0;
		if (do_wr && ((awaddr_ff == A_LAT) || (awaddr_ff == A_CLR)))
			clr = wval;
		win     = ev.evt & clr;
		nxt_lat = ((lat_ff & ~clr) | ev.evt) & VALID_MASK;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			lat_ff <= RST_LAT;
		else
			lat_ff <= nxt_lat;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			en_ff <= RST_EN;
		else if (do_wr && (awaddr_ff == A_EN))
			en_ff <= (en_ff & ~wmask) | wval;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ctl_ff <= RST_CTL;
		else if (do_wr && (awaddr_ff == A_CTL) && wstrb_ff[0])
			ctl_ff <= wdata_ff[1:0];
	end

	always_comb begin
		nxt_irq = (|(lat_ff & en_ff)) && ctl_ff[C_GRP] && ctl_ff[C_GLOB];
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_ff <= 1'b0;
		else
			irq_ff <= nxt_irq;
	end

	property p_full_set;
		ev.evt[B_JB_FULL] |=> lat_ff[B_JB_FULL];
	endproperty
	a_full_set: assert property (p_full_set) else $error("full flag not set");

	property p_empty_set;
		ev.evt[B_JB_EMPTY] |=> lat_ff[B_JB_EMPTY];
	endproperty
	a_empty_set: assert property (p_empty_set) else $error("empty flag not set");

	property p_lock_set;
		ev.evt[B_LOCK] |=> lat_ff[B_LOCK];
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock flag not set");

	property p_set_wins;
		|win |=> (lat_ff & $past(win)) == $past(win);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

	property p_hold;
		lat_ff[B_ANALOG_SIGLOSS_LIVE] && !clr[B_ANALOG_SIGLOSS_LIVE] |=> lat_ff[B_ANALOG_SIGLOSS_LIVE];
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped without clear");

	property p_irq_on;
		(|(lat_ff & en_ff)) && ctl_ff == 2'h3 |=> irq_o;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("enabled flag gave no interrupt");

	property p_irq_gate;
		irq_o |-> $past(ctl_ff) == 2'h3;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without port enables");

	property p_mask;
		!(|(lat_ff & en_ff)) |=> !irq_o;
	endproperty
	a_mask: assert property (p_mask) else $error("masked flag raised interrupt");

	property p_wr_resp;
		aw_hold_ff && w_hold_ff && !bvalid_ff |=> axi_bvalid_o ##0 $stable(awaddr_ff);
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");

	property p_drv_set;
		ev.evt[B_DRV] |=> lat_ff[B_DRV];
	endproperty
	a_drv_set: assert property (p_drv_set) else $error("driver flag not set");

	property p_txo_set;
		ev.evt[B_TX_OUT] |=> lat_ff[B_TX_OUT];
	endproperty
	a_txo_set: assert property (p_txo_set) else $error("output flag not set");

	property p_ref_set;
		ev.evt[B_REF_CLK] |=> lat_ff[B_REF_CLK];
	endproperty
	a_ref_set: assert property (p_ref_set) else $error("clock loss flag not set");

	property p_gain_set;
		ev.evt[B_GAIN_CHG] |=> lat_ff[B_GAIN_CHG];
	endproperty
	a_gain_set: assert property (p_gain_set) else $error("gain flag not set");

	property p_preamp_set;
		ev.evt[B_PREAMP] |=> lat_ff[B_PREAMP];
	endproperty
	a_preamp_set: assert property (p_preamp_set) else $error("preamp flag not set");

	property p_rx_one_set;
		ev.evt[B_RX_ONE] |=> lat_ff[B_RX_ONE];
	endproperty
	a_rx_one_set: assert property (p_rx_one_set) else $error("receive failure one flag not set");

	property p_rx_two_set;
		ev.evt[B_RX_TWO] |=> lat_ff[B_RX_TWO];
	endproperty
	a_rx_two_set: assert property (p_rx_two_set) else $error("receive failure two flag not set");

	property p_clr_drop;
		clr[B_ANALOG_SIGLOSS_LIVE] && !ev.evt[B_ANALOG_SIGLOSS_LIVE] |=> !lat_ff[B_ANALOG_SIGLOSS_LIVE];
	endproperty
	a_clr_drop: assert property (p_clr_drop) else $error("written one did not clear flag");
endmodule : lpsl_status_irq
`default_nettype wire

// ---- dv/lpsl_status_irq_test.sv ----
// Purpose: self-checking bench for the port status latch and interrupt block
// Assumes: PORT_IDX 1 so that the port base offset is exercised
// Notes: inputs move by non-blocking assignment just after the rising edge, except the last status toggle, which follows a falling edge
`timescale 1ns/1ps
`default_nettype none
module lpsl_status_irq_test;
	import lpsl_pkg::*;
	localparam int unsigned PIDX  = 1;
	localparam int          LIMIT = 20000;
	logic        core_clk_i;
	logic        arst_n_i;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic        awvalid;
	logic        wvalid;
	logic        bready;
	logic        arvalid;
	logic        rready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic        irq;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	logic [15:0] st;
	logic [7:0]  gain;
	logic [15:0] rise;
	int          fail_count;
	int          compares;
	int          cyc;
	int unsigned b;
	int unsigned bits [11] = '{B_ANALOG_SIGLOSS_LIVE, B_LOCK, B_RX_TWO, B_RX_ONE, B_PREAMP, B_REF_CLK, B_TX_OUT, B_DRV,
		B_JB_EMPTY, B_JB_FULL, B_JB_LOST};
	logic [7:0]  gains [4] = '{8'h60, 8'hf4, 8'hff, 8'h00};

	lpsl_status_irq #(.PORT_IDX(PIDX), .ADDR_W(12)) u_lpsl_status_irq (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid), .axi_awready_o(awready),
		.axi_wdata_i(wdata), .axi_wstrb_i(wstrb), .axi_wvalid_i(wvalid), .axi_wready_o(wready),
		.axi_bresp_o(bresp), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
		.axi_araddr_i(araddr), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
		.axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
		.jbuf_full_i(st[B_JB_FULL]), .jbuf_empty_i(st[B_JB_EMPTY]), .jbuf_lost_i(st[B_JB_LOST]),
		.drv_fault_live_i(st[B_DRV]), .tx_out_fault_live_i(st[B_TX_OUT]),
		.ref_clock_loss_live_i(st[B_REF_CLK]), .preamp_on_live_i(st[B_PREAMP]),
		.rx_fault_one_live_i(st[B_RX_ONE]), .rx_fault_two_live_i(st[B_RX_TWO]),
		.lock_loss_live_i(st[B_LOCK]), .analog_sigloss_live_i(st[B_ANALOG_SIGLOSS_LIVE]),
		.gain_level_value_i(gain), .irq_o(irq)
	);

	function automatic logic [11:0] ra(input int unsigned idx);
		return 12'(4 * (PIDX * PORT_STRIDE + idx));
	endfunction : ra

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: data %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: response %h expected %h", $time, got, exp);
		end
	endtask : chk_resp

	task automatic chk_irq(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: interrupt %b expected %b", $time, got, exp);
		end
	endtask : chk_irq

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic aw_go;
		logic w_go;
		logic b_go;
		logic [1:0] r;
		b_go = 1'b0;
		r = 2'h0;
		@(posedge core_clk_i);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!b_go) begin
			@(negedge core_clk_i);
			aw_go = awvalid && awready;
			w_go  = wvalid && wready;
			b_go  = bvalid && bready;
			r     = bresp;
			@(posedge core_clk_i);
			if (aw_go) awvalid <= 1'b0;
			if (w_go) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk_resp(r, er);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar_go;
		logic r_go;
		logic [31:0] d;
		logic [1:0]  r;
		r_go = 1'b0;
		d = '0;
		r = 2'h0;
		@(posedge core_clk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!r_go) begin
			@(negedge core_clk_i);
			ar_go = arvalid && arready;
			r_go  = rvalid && rready;
			d     = rdata;
			r     = rresp;
			@(posedge core_clk_i);
			if (ar_go) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk_word(d, ed);
		chk_resp(r, er);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : settle

	task automatic complete_run();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			fail_count++;
			$display("Error at %0t: run too long", $time);
			complete_run();
		end
	end

	initial begin
		arst_n_i   = 1'b0;
		awaddr     = '0;
		araddr     = '0;
		awvalid    = 1'b0;
		wvalid     = 1'b0;
		bready     = 1'b0;
		arvalid    = 1'b0;
		rready     = 1'b0;
		wdata      = '0;
		wstrb      = '0;
		st         = '0;
		gain       = '0;
		fail_count = 0;
		compares   = 0;
		cyc        = 0;
		settle(20);
		arst_n_i <= 1'b1;
		settle(10);
		rd(ra(IDX_LAT), 32'h0000_0000, RESP_OKAY);
		rd(ra(IDX_EN), 32'h0000_0000, RESP_OKAY);
		rd(ra(IDX_CTL), 32'h0000_0000, RESP_OKAY);
		rd(ra(IDX_LIVE), 32'h0000_0000, RESP_OKAY);
		// the other port's copy is not decoded here
		rd(12'(4 * IDX_LAT), 32'h0000_0000, RESP_SLVERR);
		wr(12'(4 * IDX_EN), 32'hffff_ffff, 4'hf, RESP_SLVERR);
		wr(ra(IDX_EN), 32'hffff_ffff, 4'hf, RESP_OKAY);
		rd(ra(IDX_EN), {16'h0000, VALID_MASK}, RESP_OKAY);
		wr(ra(IDX_EN), 32'h0000_0000, 4'h1, RESP_OKAY);
		rd(ra(IDX_EN), 32'h0000_1f00, RESP_OKAY);
		wr(ra(IDX_EN), 32'h0000_0000, 4'hf, RESP_OKAY);
		wr(ra(IDX_GAIN), 32'hffff_ffff, 4'hf, RESP_OKAY);
		rd(ra(IDX_GAIN), 32'h0000_0000, RESP_OKAY);
		foreach (bits[i]) begin
			b = bits[i];
			rise = (b == B_JB_LOST) ? ((16'h0001 << B_JB_FULL) | (16'h0001 << B_JB_EMPTY)) : (16'h0001 << b);
			st[b] <= 1'b1;
			settle(10);
			rd(ra(IDX_LIVE), {16'h0000, st & LIVE_MASK}, RESP_OKAY);
			rd(ra(IDX_LAT), {16'h0000, rise}, RESP_OKAY);
			wr(ra(IDX_LAT), {16'h0000, rise}, 4'hf, RESP_OKAY);
			rd(ra(IDX_LAT), 32'h0000_0000, RESP_OKAY);
			st[b] <= 1'b0;
			settle(10);
			rd(ra(IDX_LAT), {16'h0000, rise & CHG_MASK}, RESP_OKAY);
			wr(ra(IDX_CLR), 32'h0000_ffff, 4'hf, RESP_OKAY);
			rd(ra(IDX_LAT), 32'h0000_0000, RESP_OKAY);
		end
		foreach (gains[i]) begin
			gain <= gains[i];
			settle(10);
			rd(ra(IDX_GAIN), {24'h00_0000, gains[i]}, RESP_OKAY);
			rd(ra(IDX_LAT), 32'h0000_0020, RESP_OKAY);
			wr(ra(IDX_CLR), 32'h0000_0020, 4'hf, RESP_OKAY);
		end
		rd(ra(IDX_CLR), 32'h0000_0000, RESP_OKAY);
		// every combination of group and global enable with the flag enabled
		wr(ra(IDX_EN), 32'h0000_0001, 4'hf, RESP_OKAY);
		for (int c = 0; c < 4; c++) begin
			wr(ra(IDX_CTL), 32'(c), 4'hf, RESP_OKAY);
			st[B_ANALOG_SIGLOSS_LIVE] <= ~st[B_ANALOG_SIGLOSS_LIVE];
			settle(10);
			@(negedge core_clk_i);
			chk_irq(irq, c == 3);
			wr(ra(IDX_CLR), 32'h0000_0001, 4'hf, RESP_OKAY);
			settle(3);
			@(negedge core_clk_i);
			chk_irq(irq, 1'b0);
		end
		rd(ra(IDX_CTL), 32'h0000_0003, RESP_OKAY);
		// flag raised while masked, then unmasked late
		wr(ra(IDX_EN), 32'h0000_0000, 4'hf, RESP_OKAY);
		st[B_ANALOG_SIGLOSS_LIVE] <= ~st[B_ANALOG_SIGLOSS_LIVE];
		settle(10);
		@(negedge core_clk_i);
		chk_irq(irq, 1'b0);
		wr(ra(IDX_EN), 32'h0000_0001, 4'hf, RESP_OKAY);
		settle(3);
		@(negedge core_clk_i);
		chk_irq(irq, 1'b1);
		rd(ra(IDX_LAT), 32'h0000_0001, RESP_OKAY);
		wr(ra(IDX_LAT), 32'h0000_0001, 4'hf, RESP_OKAY);
		settle(3);
		@(negedge core_clk_i);
		chk_irq(irq, 1'b0);
		// event pulse lands in the same cycle as the clear write, so the flag must stay set
		st[B_ANALOG_SIGLOSS_LIVE] <= ~st[B_ANALOG_SIGLOSS_LIVE];
		settle(1);
		wr(ra(IDX_CLR), 32'h0000_0001, 4'hf, RESP_OKAY);
		rd(ra(IDX_LAT), 32'h0000_0001, RESP_OKAY);
		@(negedge core_clk_i);
		chk_irq(irq, 1'b1);
		complete_run();
	end
endmodule : lpsl_status_irq_test
`default_nettype wire
